// File: pisc_pkg.sv
package pisc_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [5:0] ADDR_STATUS = 6'h13;
    localparam logic [5:0] ADDR_LATCH = 6'h14;
    localparam logic [5:0] ADDR_LINE_VIEW = 6'h15;
    localparam logic [5:0] ADDR_SPARE = 6'h16;
    localparam logic [5:0] ADDR_ACC_CTRL = 6'h19;
    localparam logic [5:0] ADDR_ACC_IRQ_EN = 6'h1D;
    localparam logic [5:0] ALIAS_SET = 6'h01;
    localparam logic [5:0] ALIAS_CLR = 6'h02;

    // ************************************************************
    // source bit positions in status and latch
    // ************************************************************
    localparam int SRC_HOST_DETACH = 0;
    localparam int SRC_BUS_POWER_OK = 1;
    localparam int SRC_SESSION_OK = 2;
    localparam int SRC_SESSION_OVER = 3;
    localparam int SRC_ID_GROUNDED = 4;
    localparam int SRC_COUNT = 5;

    // ************************************************************
    // accessory control fields
    // ************************************************************
    localparam int ACC_POWER_BIT = 0;
    localparam int ACC_ID_PULL_LOW = 1;
    localparam int ACC_UART_TX_ROUTE = 2;
    localparam int ACC_UART_RX_ROUTE = 3;
    localparam int ACC_LEFT_AUDIO = 4;
    localparam int ACC_RIGHT_AUDIO = 5;
    localparam int ACC_MIC_ROUTE = 6;
    localparam int ACC_DATA2_FLOAT = 7;

    // ************************************************************
    // accessory interrupt enable fields
    // ************************************************************
    localparam int IEN_ID_OPEN_RISE = 0;
    localparam int IEN_ID_OPEN_FALL = 1;
    localparam int IEN_LINE_VOLTAGE = 2;
    localparam int IEN_ID_CONV = 5;

    // ************************************************************
    // writable masks and reset values
    // ************************************************************
    localparam logic [7:0] SPARE_MASK = 8'hFF;
    localparam logic [7:0] ACC_CTRL_MASK = 8'hFE;
    localparam logic [7:0] ACC_IRQ_EN_MASK = 8'h27;
    localparam logic [7:0] SPARE_RESET = 8'h00;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACC_IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ************************************************************
    // edge detector slice of the sampled inputs
    // ************************************************************
    localparam int EDGE_WIDTH = 8;
    localparam int EDGE_ID_OPEN = 5;
    localparam int EDGE_LINE_VOLTAGE = 6;
    localparam int EDGE_ID_CONV = 7;

endpackage

// File: pisc_edge_detect.sv
`timescale 1ns/1ps

module pisc_edge_detect #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sampled levels
    input wire logic [WIDTH-1:0] level,
    // one-cycle edge flags
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    // ************************************************************
    // previous sample, primed after first cycle
    // ************************************************************
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;
    logic primed_q;
    logic primed_d;

    always_comb
    begin
        prev_d = level;
        primed_d = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            primed_q <= primed_d;
        end
    end

    // no edges reported before the first real sample
    always_comb
    begin
        rise = primed_q ? (level & ~prev_q) : '0;
        fall = primed_q ? (~level & prev_q) : '0;
    end

endmodule

// File: pisc_regs.sv
`timescale 1ns/1ps
// Behaviour
// - status byte shows live detach (host mode only), power, session, over, id-ground; upper bits zero
// - bus-power-ok status reads zero when both its edge enables set
// - session-ok status always shows the live comparator
// - session-over status reads zero when both its edge enables set
// - status is not stored; each read, the first after reset too, samples the inputs
// - latch bit sets on unmasked source event; detach only in host mode
// - reading the latch returns it and clears all bits except those set by an event in the same cycle
// - line view returns line state on low two bits, rest zero
// - spare byte resets to zero, read/write/set/clear, drives nothing
// - writable registers decode base write, base+1 set, base+2 clear; all read back
// - data bit 1 held high while uart receive route clear
// - control bits route tx to dm, rx from dp, pull id low; bit0 zero
// - bit4 connects dm to left speaker; bit5 or bit6 connects dp to right
// - bit7 floats data bit 2 in accessory mode, else drives zero
// - in uart mode speaker pins follow the audio route bits only and never carry uart data
// - single-ended receivers off while any audio route is set
// - id open rise and fall enables raise alt_int on id float changes
// - line voltage enable raises alt_int on detect comparator change
// - id conversion enable, ored with vendor copy, raises alt_int on done
// - irq enable bits 3,4,6,7 read zero and ignore writes
// - event unmasked only when the matching edge enable is set

module pisc_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register transaction port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // interrupt sources and edge enables
    input wire logic hostMode,
    input wire logic hostDetach,
    input wire logic busPowerOk,
    input wire logic session_ok,
    input wire logic session_over,
    input wire logic id_grounded,
    input wire logic [4:0] riseEnable,
    input wire logic [4:0] fallEnable,
    input wire logic [1:0] lineState,
    // accessory sources
    input wire logic accessory_mode_bit,
    input wire logic idFloating,
    input wire logic line_voltage_detect,
    input wire logic id_conv_finished,
    input wire logic vendorIdConvIrqEn,
    // uart data
    input wire logic uartTxData,
    input wire logic dpRxData,
    // switch controls
    output logic id_pull_low,
    output logic dmTxEnable,
    output logic dmTxData,
    output logic left_speaker_pin,
    output logic right_speaker_pin,
    output logic seReceiverDisable,
    // ulpi data pins 1 and 2
    output logic data1Out,
    output logic data1Oe,
    output logic data2Out,
    output logic data2Oe,
    // interrupt to rxcmd
    output logic altIntPulse
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] spare_q;
    logic [7:0] spare_d;
    logic [7:0] accCtrl_q;
    logic [7:0] accCtrl_d;
    logic [7:0] irqEn_q;
    logic [7:0] irqEn_d;
    logic [4:0] latch_q;
    logic [4:0] latch_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic rdValid_q;
    logic rdValid_d;
    logic [9:0] pins_q;
    logic [9:0] pins_d;
    logic altInt_q;
    logic altInt_d;

    // ************************************************************
    // edge detection
    // ************************************************************
    logic [pisc_pkg::EDGE_WIDTH-1:0] levels;
    logic [pisc_pkg::EDGE_WIDTH-1:0] rises;
    logic [pisc_pkg::EDGE_WIDTH-1:0] falls;
    logic [4:0] srcLevel;
    logic [4:0] srcEvent;
    logic [7:0] liveStatus;

    assign srcLevel = {id_grounded, session_over, session_ok, busPowerOk, hostDetach};
    assign levels = {id_conv_finished, line_voltage_detect, idFloating, srcLevel};

    pisc_edge_detect #(
        .WIDTH(pisc_pkg::EDGE_WIDTH)
    ) uEdge (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(levels),
        .rise(rises),
        .fall(falls)
    );

    // ************************************************************
    // live status and events
    // ************************************************************
    always_comb
    begin
        liveStatus = 8'h00;
        liveStatus[pisc_pkg::SRC_HOST_DETACH] = hostDetach & hostMode;
        liveStatus[pisc_pkg::SRC_BUS_POWER_OK] = busPowerOk
            & ~(riseEnable[pisc_pkg::SRC_BUS_POWER_OK]
            & fallEnable[pisc_pkg::SRC_BUS_POWER_OK]);
        liveStatus[pisc_pkg::SRC_SESSION_OK] = session_ok;
        liveStatus[pisc_pkg::SRC_SESSION_OVER] = session_over
            & ~(riseEnable[pisc_pkg::SRC_SESSION_OVER]
            & fallEnable[pisc_pkg::SRC_SESSION_OVER]);
        liveStatus[pisc_pkg::SRC_ID_GROUNDED] = id_grounded;
        srcEvent = (rises[4:0] & riseEnable) | (falls[4:0] & fallEnable);
        srcEvent[pisc_pkg::SRC_HOST_DETACH] = srcEvent[pisc_pkg::SRC_HOST_DETACH]
            & hostMode;
    end

    // ************************************************************
    // decode
    // ************************************************************
    logic [5:0] addrOff;
    logic hitSpare;
    logic hitCtrl;
    logic hitIen;
    logic [1:0] wrKind;

    always_comb
    begin
        hitSpare = 1'b0;
        hitCtrl = 1'b0;
        hitIen = 1'b0;
        addrOff = 6'h00;
        if (regAddr >= pisc_pkg::ADDR_SPARE
            && regAddr <= pisc_pkg::ADDR_SPARE + pisc_pkg::ALIAS_CLR)
        begin
            hitSpare = 1'b1;
            addrOff = regAddr - pisc_pkg::ADDR_SPARE;
        end
        else if (regAddr >= pisc_pkg::ADDR_ACC_CTRL
            && regAddr <= pisc_pkg::ADDR_ACC_CTRL + pisc_pkg::ALIAS_CLR)
        begin
            hitCtrl = 1'b1;
            addrOff = regAddr - pisc_pkg::ADDR_ACC_CTRL;
        end
        else if (regAddr >= pisc_pkg::ADDR_ACC_IRQ_EN
            && regAddr <= pisc_pkg::ADDR_ACC_IRQ_EN + pisc_pkg::ALIAS_CLR)
        begin
            hitIen = 1'b1;
            addrOff = regAddr - pisc_pkg::ADDR_ACC_IRQ_EN;
        end
        wrKind = addrOff[1:0];
    end

    // plain, set or clear update of one writable byte
    function automatic logic [7:0] applyWrite(
        input logic [7:0] cur,
        input logic [7:0] wd,
        input logic [1:0] kind,
        input logic [7:0] mask
    );
        logic [7:0] nxt;
        nxt = wd;
        if (kind == pisc_pkg::ALIAS_SET[1:0])
        begin
            nxt = cur | wd;
        end
        else if (kind == pisc_pkg::ALIAS_CLR[1:0])
        begin
            nxt = cur & ~wd;
        end
        return (nxt & mask) | (cur & ~mask);
    endfunction

    // ************************************************************
    // register file next state
    // ************************************************************
    always_comb
    begin
        spare_d = spare_q;
        accCtrl_d = accCtrl_q;
        irqEn_d = irqEn_q;
        if (regWrEn && hitSpare)
            spare_d = applyWrite(spare_q, regWrData, wrKind, pisc_pkg::SPARE_MASK);
        if (regWrEn && hitCtrl)
            accCtrl_d = applyWrite(accCtrl_q, regWrData, wrKind, pisc_pkg::ACC_CTRL_MASK);
        if (regWrEn && hitIen)
            irqEn_d = applyWrite(irqEn_q, regWrData, wrKind,
                pisc_pkg::ACC_IRQ_EN_MASK);
        latch_d = latch_q;
        if (regRdEn && regAddr == pisc_pkg::ADDR_LATCH)
            latch_d = 5'h00;
        latch_d = latch_d | srcEvent;
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb
    begin
        rdValid_d = regRdEn;
        rdData_d = rdData_q;
        if (regRdEn)
        begin
            rdData_d = pisc_pkg::READ_IDLE;
            if (regAddr == pisc_pkg::ADDR_STATUS)
                rdData_d = liveStatus;
            else if (regAddr == pisc_pkg::ADDR_LATCH)
                rdData_d = {3'h0, latch_q};
            else if (regAddr == pisc_pkg::ADDR_LINE_VIEW)
                rdData_d = {6'h00, lineState};
            else if (hitSpare)
                rdData_d = spare_q;
            else if (hitCtrl)
                rdData_d = accCtrl_q;
            else if (hitIen)
                rdData_d = irqEn_q;
        end
    end

    // ************************************************************
    // switch, pin and interrupt outputs
    // ************************************************************
    logic anyAudio;
    logic idConvEn;

    always_comb
    begin
        anyAudio = accCtrl_q[pisc_pkg::ACC_LEFT_AUDIO] | accCtrl_q[pisc_pkg::ACC_RIGHT_AUDIO]
            | accCtrl_q[pisc_pkg::ACC_MIC_ROUTE];
        idConvEn = irqEn_q[pisc_pkg::IEN_ID_CONV] | vendorIdConvIrqEn;
        pins_d[0] = accCtrl_q[pisc_pkg::ACC_ID_PULL_LOW];
        pins_d[1] = accCtrl_q[pisc_pkg::ACC_UART_TX_ROUTE];
        pins_d[2] = uartTxData;
        // speaker switches follow bits 4 to 6 only; uart mode neither opens nor closes them
        pins_d[3] = accCtrl_q[pisc_pkg::ACC_LEFT_AUDIO];
        pins_d[4] = accCtrl_q[pisc_pkg::ACC_RIGHT_AUDIO]
            | accCtrl_q[pisc_pkg::ACC_MIC_ROUTE];
        pins_d[5] = anyAudio;
        pins_d[6] = accCtrl_q[pisc_pkg::ACC_UART_RX_ROUTE] ? dpRxData : 1'b1;
        pins_d[7] = accessory_mode_bit;
        pins_d[8] = 1'b0;
        pins_d[9] = accessory_mode_bit & ~accCtrl_q[pisc_pkg::ACC_DATA2_FLOAT];
        altInt_d = (rises[pisc_pkg::EDGE_ID_OPEN] & irqEn_q[pisc_pkg::IEN_ID_OPEN_RISE])
            | (falls[pisc_pkg::EDGE_ID_OPEN] & irqEn_q[pisc_pkg::IEN_ID_OPEN_FALL])
            | ((rises[pisc_pkg::EDGE_LINE_VOLTAGE] | falls[pisc_pkg::EDGE_LINE_VOLTAGE])
            & irqEn_q[pisc_pkg::IEN_LINE_VOLTAGE])
            | (rises[pisc_pkg::EDGE_ID_CONV] & idConvEn);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            spare_q <= pisc_pkg::SPARE_RESET;
            accCtrl_q <= pisc_pkg::ACC_CTRL_RESET;
            irqEn_q <= pisc_pkg::ACC_IRQ_EN_RESET;
            latch_q <= 5'h00;
            rdData_q <= pisc_pkg::READ_IDLE;
            rdValid_q <= 1'b0;
            pins_q <= 10'h000;
            altInt_q <= 1'b0;
        end
        else
        begin
            spare_q <= spare_d;
            accCtrl_q <= accCtrl_d;
            irqEn_q <= irqEn_d;
            latch_q <= latch_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
            pins_q <= pins_d;
            altInt_q <= altInt_d;
        end
    end

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign id_pull_low = pins_q[0];
    assign dmTxEnable = pins_q[1];
    assign dmTxData = pins_q[2];
    assign left_speaker_pin = pins_q[3];
    assign right_speaker_pin = pins_q[4];
    assign seReceiverDisable = pins_q[5];
    assign data1Out = pins_q[6];
    assign data1Oe = pins_q[7];
    assign data2Out = pins_q[8];
    assign data2Oe = pins_q[9];
    assign altIntPulse = altInt_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_status_read: assert property (
        regRdEn && regAddr == pisc_pkg::ADDR_STATUS |=> regRdValid
        && regRdData == $past(liveStatus) && regRdData[7:5] == 3'h0)
        else $error("status read mismatch");

    chk_power_masked: assert property (
        regRdEn && regAddr == pisc_pkg::ADDR_STATUS && riseEnable[1] && fallEnable[1]
        |=> regRdData[1] == 1'b0)
        else $error("bus power bit not masked");

    chk_latch_clear: assert property (
        regRdEn && regAddr == pisc_pkg::ADDR_LATCH && srcEvent == 5'h00
        |=> latch_q == 5'h00 && regRdData == {3'h0, $past(latch_q)})
        else $error("latch not cleared by read");

    chk_latch_set: assert property (
        srcEvent != 5'h00 |=> (latch_q & $past(srcEvent)) == $past(srcEvent))
        else $error("latch lost an event");

    chk_spare_set: assert property (
        regWrEn && regAddr == pisc_pkg::ADDR_SPARE + pisc_pkg::ALIAS_SET
        |=> spare_q == ($past(spare_q) | $past(regWrData)))
        else $error("set alias wrong");

    chk_ien_reserved: assert property (
        (irqEn_q & ~pisc_pkg::ACC_IRQ_EN_MASK) == 8'h00 && accCtrl_q[0] == 1'b0)
        else $error("reserved bits set");

    chk_data1_high: assert property (
        accessory_mode_bit && !accCtrl_q[pisc_pkg::ACC_UART_RX_ROUTE] |=> data1Oe && data1Out)
        else $error("data1 not held high");

    chk_data2_drive: assert property (
        accessory_mode_bit |=> data2Oe == !$past(accCtrl_q[pisc_pkg::ACC_DATA2_FLOAT])
        && !data2Out)
        else $error("data2 drive wrong");

    chk_se_disable: assert property (
        accCtrl_q[6:4] != 3'h0 |=> seReceiverDisable)
        else $error("receivers not disabled");

    chk_alt_vdat: assert property (
        irqEn_q[pisc_pkg::IEN_LINE_VOLTAGE] && rises[pisc_pkg::EDGE_LINE_VOLTAGE] |=> altIntPulse)
        else $error("alt_int missed");

endmodule

// File: pisc_link_model.sv
`timescale 1ns/1ps

module pisc_link_model (
    // clock
    input wire logic clk,
    // register transaction port
    output logic regWrEn,
    output logic regRdEn,
    output logic [5:0] regAddr,
    output logic [7:0] regWrData,
    // interface control mode bit
    output logic accessory_mode_bit
);
    initial
    begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 6'h00;
        regWrData = 8'h00;
        accessory_mode_bit = 1'b0;
    end

    // ************************************************************
    // register transactions, entered just after a falling edge
    // ************************************************************
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regWrData = ~d;
        @(negedge clk);
    endtask

    task automatic read_reg(input logic [5:0] a);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        @(negedge clk);
    endtask

    // ************************************************************
    // mode entry and exit
    // ************************************************************
    task automatic enter_uart(input logic [7:0] ctrl);
        logic [7:0] c;
        c = ctrl;
        if ((c & 8'h0C) != 8'h00)
        begin
            c = c & 8'h8F;
        end
        write_reg(pisc_pkg::ADDR_ACC_CTRL, c);
        accessory_mode_bit = 1'b1;
        @(negedge clk);
    endtask

    task automatic leave_mode();
        accessory_mode_bit = 1'b0;
        @(negedge clk);
    endtask
endmodule

// File: pisc_regs_tb.sv
`timescale 1ns/1ps

module pisc_regs_tb;
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin mismatches++; \
$display("[FAIL] %s exp=%h got=%h", nm, e, g); end end

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hostMode = 1'b0;
    logic [4:0] src = 5'h00;
    logic [4:0] riseEn = 5'h00;
    logic [4:0] fallEn = 5'h00;
    logic [1:0] lineState = 2'h0;
    logic idFloating = 1'b0;
    logic lineVolt = 1'b0;
    logic idConvDone = 1'b0;
    logic vendorEn = 1'b0;
    logic uartTx = 1'b0;
    logic dpRx = 1'b0;
    logic regWrEn, regRdEn, accMode;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic regRdValid, idPullLow, dmTxEnable, dmTxData, leftSpk, rightSpk, seRxOff;
    logic data1Out, data1Oe, data2Out, data2Oe, altIntPulse;
    logic [15:0] expQ[$];
    logic [15:0] e;
    logic [5:0] bases[3] = '{pisc_pkg::ADDR_SPARE, pisc_pkg::ADDR_ACC_CTRL,
        pisc_pkg::ADDR_ACC_IRQ_EN};
    logic [7:0] masks[3] = '{pisc_pkg::SPARE_MASK, pisc_pkg::ACC_CTRL_MASK,
        pisc_pkg::ACC_IRQ_EN_MASK};
    logic [7:0] v;
    logic [31:0] r;
    int seed = 41391;
    int mismatches = 0;
    int totalChecks = 0;
    int pulseCount = 0;
    int pc0;

    initial
    begin
        forever #20 clk = ~clk;
    end

    pisc_link_model link (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .accessory_mode_bit(accMode));

    pisc_regs dut (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .hostMode(hostMode), .hostDetach(src[0]),
        .busPowerOk(src[1]), .session_ok(src[2]), .session_over(src[3]),
        .id_grounded(src[4]), .riseEnable(riseEn), .fallEnable(fallEn),
        .lineState(lineState), .accessory_mode_bit(accMode), .idFloating(idFloating),
        .line_voltage_detect(lineVolt), .id_conv_finished(idConvDone),
        .vendorIdConvIrqEn(vendorEn), .uartTxData(uartTx), .dpRxData(dpRx),
        .id_pull_low(idPullLow), .dmTxEnable(dmTxEnable), .dmTxData(dmTxData),
        .left_speaker_pin(leftSpk), .right_speaker_pin(rightSpk),
        .seReceiverDisable(seRxOff), .data1Out(data1Out), .data1Oe(data1Oe),
        .data2Out(data2Out), .data2Oe(data2Oe), .altIntPulse(altIntPulse));

    // ************************************************************
    // read result monitor and pulse counter
    // ************************************************************
    always @(negedge clk)
    begin
        if (regRdValid === 1'b1)
        begin
            if (expQ.size() == 0)
            begin
                mismatches++;
                $display("[FAIL] regRdData exp=none got=%h", regRdData);
            end
            else
            begin
                e = expQ.pop_front();
                `CHK("regRdData", e[7:0] & e[15:8], regRdData & e[15:8])
            end
        end
    end

    always @(negedge clk)
    begin
        if (altIntPulse === 1'b1)
        begin
            pulseCount++;
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic rd(input logic [5:0] a, input logic [7:0] x, input logic [7:0] m);
        expQ.push_back({m, x});
        link.read_reg(a);
    endtask

    function automatic logic [7:0] statExp();
        return {3'b000, src[4], src[3] & ~(riseEn[3] & fallEn[3]), src[2],
            src[1] & ~(riseEn[1] & fallEn[1]), src[0] & hostMode};
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && totalChecks > 0 && expQ.size() == 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        mismatches++;
        finish_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        rd(pisc_pkg::ADDR_STATUS, 8'h00, 8'hFF);
        rd(pisc_pkg::ADDR_LATCH, 8'h00, 8'hFF);
        rd(pisc_pkg::ADDR_SPARE, pisc_pkg::SPARE_RESET, 8'hFF);
        rd(pisc_pkg::ADDR_ACC_CTRL, 8'h00, 8'hFF);
        rd(pisc_pkg::ADDR_ACC_IRQ_EN, 8'h00, 8'hFF);
        rd(6'h25, pisc_pkg::READ_IDLE, 8'hFF);
        for (int i = 0; i < 10; i++)
        begin
            r = $random(seed);
            {lineState, hostMode, fallEn, riseEn, src} = r[17:0];
            if (i < 2)
            begin
                riseEn = 5'h1F;
                fallEn = 5'h1F;
            end
            rd(pisc_pkg::ADDR_STATUS, statExp(), 8'hFF);
            rd(pisc_pkg::ADDR_LINE_VIEW, {6'h00, lineState}, 8'hFF);
        end
        // latch set, auto clear and edge masking
        src = 5'h00;
        riseEn = 5'h1F;
        fallEn = 5'h00;
        hostMode = 1'b1;
        repeat (3) @(negedge clk);
        rd(pisc_pkg::ADDR_LATCH, 8'h00, 8'hE0);
        src[2:1] = 2'b11;
        repeat (3) @(negedge clk);
        rd(pisc_pkg::ADDR_LATCH, 8'h06, 8'hFF);
        rd(pisc_pkg::ADDR_LATCH, 8'h00, 8'hFF);
        src[1] = 1'b0;
        repeat (3) @(negedge clk);
        rd(pisc_pkg::ADDR_LATCH, 8'h00, 8'hFF);
        hostMode = 1'b0;
        src[0] = 1'b1;
        src[4] = 1'b1;
        repeat (3) @(negedge clk);
        rd(pisc_pkg::ADDR_LATCH, 8'h10, 8'hFF);
        // write, set and clear aliases
        for (int b = 0; b < 3; b++)
        begin
            r = $random(seed);
            link.write_reg(bases[b], r[7:0]);
            v = r[7:0] & masks[b];
            rd(bases[b], v, 8'hFF);
            link.write_reg(bases[b] + pisc_pkg::ALIAS_SET, r[15:8]);
            v = (v | r[15:8]) & masks[b];
            rd(bases[b] + pisc_pkg::ALIAS_SET, v, 8'hFF);
            link.write_reg(bases[b] + pisc_pkg::ALIAS_CLR, r[23:16]);
            v = v & ~r[23:16];
            rd(bases[b] + pisc_pkg::ALIAS_CLR, v, 8'hFF);
        end
        link.write_reg(pisc_pkg::ADDR_LINE_VIEW, 8'hFF);
        rd(pisc_pkg::ADDR_LINE_VIEW, {6'h00, lineState}, 8'hFF);
        // switch controls, one bit at a time
        for (int k = 1; k < 8; k++)
        begin
            v = 8'h01 << k;
            link.write_reg(pisc_pkg::ADDR_ACC_CTRL, v);
            `CHK("id_pull_low", v[1], idPullLow)
            `CHK("dmTxEnable", v[2], dmTxEnable)
            `CHK("left_speaker_pin", v[4], leftSpk)
            `CHK("right_speaker_pin", v[5] | v[6], rightSpk)
            `CHK("seReceiverDisable", v[4] | v[5] | v[6], seRxOff)
        end
        // uart mode data pins
        link.enter_uart(8'h0C);
        for (int t = 0; t < 2; t++)
        begin
            dpRx = t[0];
            uartTx = ~t[0];
            repeat (2) @(negedge clk);
            `CHK("data1Oe", 1'b1, data1Oe)
            `CHK("data1Out", dpRx, data1Out)
            `CHK("dmTxData", uartTx, dmTxData)
            `CHK("data2Oe", 1'b1, data2Oe)
            `CHK("data2Out", 1'b0, data2Out)
        end
        dpRx = 1'b0;
        link.write_reg(pisc_pkg::ADDR_ACC_CTRL + pisc_pkg::ALIAS_CLR, 8'h08);
        link.write_reg(pisc_pkg::ADDR_ACC_CTRL + pisc_pkg::ALIAS_SET, 8'h80);
        `CHK("data1Out", 1'b1, data1Out)
        `CHK("data2Oe", 1'b0, data2Oe)
        link.leave_mode();
        @(negedge clk);
        `CHK("data1Oe", 1'b0, data1Oe)
        // accessory interrupt pulses
        link.write_reg(pisc_pkg::ADDR_ACC_IRQ_EN, 8'h05);
        pc0 = pulseCount;
        for (int s = 0; s < 5; s++)
        begin
            {idConvDone, lineVolt, idFloating} = (s == 0) ? 3'b001 : (s == 1) ? 3'b000 :
                (s == 2) ? 3'b010 : (s == 3) ? 3'b000 : 3'b100;
            repeat (3) @(negedge clk);
        end
        `CHK("altIntPulse count", 3, pulseCount - pc0)
        vendorEn = 1'b1;
        idConvDone = 1'b0;
        repeat (3) @(negedge clk);
        idConvDone = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("altIntPulse count", 4, pulseCount - pc0)
        // fall enable and own conversion enable, vendor copy off
        vendorEn = 1'b0;
        link.write_reg(pisc_pkg::ADDR_ACC_IRQ_EN, 8'h22);
        idConvDone = 1'b0;
        idFloating = 1'b1;
        repeat (3) @(negedge clk);
        idFloating = 1'b0;
        repeat (3) @(negedge clk);
        idConvDone = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("altIntPulse count", 6, pulseCount - pc0)
        repeat (2) @(negedge clk);
        finish_test();
    end
endmodule
